// file: core/async_serial_pkg.sv
// Constants and carrier types shared by the asynchronous serial receiver
package async_serial_pkg;
	// ====================================================================
	// Clock and bit rate
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned OVERSAMPLE = 16;
	localparam logic [11:0] RELOAD_600 = 12'((CLK_HZ + 600 * 8) / (600 * OVERSAMPLE) - 1);
	localparam logic [11:0] RELOAD_1200 = 12'((CLK_HZ + 1200 * 8) / (1200 * OVERSAMPLE) - 1);
	localparam logic [11:0] RELOAD_2400 = 12'((CLK_HZ + 2400 * 8) / (2400 * OVERSAMPLE) - 1);
	localparam logic [11:0] RELOAD_4800 = 12'((CLK_HZ + 4800 * 8) / (4800 * OVERSAMPLE) - 1);
	localparam logic [11:0] RELOAD_9600 = 12'((CLK_HZ + 9600 * 8) / (9600 * OVERSAMPLE) - 1);
	localparam logic [11:0] RELOAD_19200 = 12'((CLK_HZ + 19200 * 8) / (19200 * OVERSAMPLE) - 1);
	localparam logic [11:0] RELOAD_38400 = 12'((CLK_HZ + 38400 * 8) / (38400 * OVERSAMPLE) - 1);

	// ====================================================================
	// Register offsets
	localparam logic [7:0] PIN_FN_ADDR = 8'h10;
	localparam logic [7:0] HOLD_ADDR = 8'h12;
	localparam logic [7:0] STATUS_ADDR = 8'h13;
	localparam logic [7:0] FRAME_CFG_ADDR = 8'h14;
	localparam logic [7:0] FRAME_CFG_RESET = 8'h00;
	localparam logic [3:0] PIN_FN_RESET = 4'h0;

	// ====================================================================
	// Field positions
	localparam int RX_ON_BIT = 1;
	localparam int LAYOUT_LSB = 2;
	localparam int PARITY_SEL_BIT = 4;
	localparam int RATE_LSB = 5;
	localparam int TX_PIN_SELECT = 3;
	localparam int ST_FULL = 0;
	localparam int ST_LOST = 1;
	localparam int ST_NOISE = 2;
	localparam int ST_FRAMING = 3;
	localparam int ST_BREAK = 4;
	localparam int ST_NINTH = 5;

	// ====================================================================
	// Sample and bit counts
	localparam logic [3:0] VOTE_FIRST = 4'h7;
	localparam logic [3:0] VOTE_MID = 4'h8;
	localparam logic [3:0] VOTE_LAST = 4'h9;
	localparam logic [3:0] STOP_IDX_SHORT = 4'h8;
	localparam logic [3:0] STOP_IDX_LONG = 4'h9;
	localparam logic [3:0] BREAK_BITS = 4'hA;
	localparam logic [1:0] BUF_DEPTH = 2'h2;

	// ====================================================================
	// Types
	typedef enum logic [1:0] {
		LAYOUT_8N1 = 2'b00,
		LAYOUT_8N2 = 2'b01,
		LAYOUT_8P1 = 2'b10,
		LAYOUT_9N1 = 2'b11
	} layout_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_BITS = 2'b10
	} rx_state_t;

	typedef struct packed {
		logic framing;
		logic noise;
		logic [8:0] data;
	} char_t;

	typedef struct packed {
		logic [11:0] baudCnt;
		rx_state_t rxState;
		logic [2:0] history;
		logic [3:0] sampleCnt;
		logic [1:0] votes;
		logic [3:0] bitCnt;
		logic [9:0] shiftReg;
		logic noiseAcc;
		logic [3:0] lowRun;
		char_t [1:0] fifo;
		logic wrPtr;
		logic rdPtr;
		logic [1:0] fifoCount;
		char_t hold;
		logic holdFull;
		logic lostWord;
		logic breakFlag;
		logic breakIrq;
		logic [7:0] frameCfg;
		logic [3:0] pinFn;
		logic [7:0] rdData;
		logic serialOut;
	} state_t;

	// Reload value of the oversample divider; zero for the unused code
	function automatic logic [11:0] rate_reload(input logic [2:0] sel);
		case (sel)
			3'h0: return RELOAD_600;
			3'h1: return RELOAD_1200;
			3'h2: return RELOAD_2400;
			3'h3: return RELOAD_4800;
			3'h4: return RELOAD_9600;
			3'h5: return RELOAD_19200;
			3'h6: return RELOAD_38400;
			default: return 12'h000;
		endcase
	endfunction
endpackage

// file: core/async_serial_receiver.sv
// Receive path of the asynchronous serial port with holding buffer and pin routing
//
// Summary of operation
// - Frame: start, 8 or 9 data, stop
// - Bit rates up to 38400 selectable
// - Receiver runs only while enable bit set
// - Serial input sampled at sixteen times rate
// - Start: low sample after three highs
// - Layout field selects acquisition sequence
// - Parity select bit picks odd or even
// - Stop moves character into two-entry buffer, then into holding buffer when empty
// - Transfer sets receive-full flag
// - Reading holding buffer clears full flag
// - New character while holding and both buffer entries are full sets overrun
// - Overrun keeps unread holding contents
// - Pin bit routes transmit output pin
// - Layout codes: 8N1, 8N2, 8P1, 9N1
// - Three-sample majority, disagreement sets noise
// - Bad parity or stop sets framing
// - Ten low bits flag break, interrupt
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module async_serial_receiver
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output logic [7:0] regRdData,
	// Serial pins
	input wire logic serialInPin,
	input wire logic txSerial,
	input wire logic portCOut,
	output logic serialOutPin,
	// Status
	output logic rxFullFlag,
	output logic breakIrq
);
	// ====================================================================
	// State
	async_serial_pkg::state_t st;
	async_serial_pkg::state_t next_st;
	async_serial_pkg::layout_t layout;
	async_serial_pkg::char_t doneChar;
	logic tick;
	logic vote;
	logic noisy;
	logic doneValid;
	logic bitDecided;
	logic fifoReady;
	logic [3:0] stopIdx;
	logic parityBad;

	// Outputs come straight from the state register
	assign regRdData = st.rdData;
	assign serialOutPin = st.serialOut;
	assign rxFullFlag = st.holdFull;
	assign breakIrq = st.breakIrq;

	// ====================================================================
	// Next-state logic
	always_comb
	begin
		next_st = st;
		layout = async_serial_pkg::layout_t'(st.frameCfg[async_serial_pkg::LAYOUT_LSB +: 2]);
		tick = 1'b0;
		doneValid = 1'b0;
		bitDecided = 1'b0;
		doneChar = '0;
		next_st.breakIrq = 1'b0;
		fifoReady = (st.fifoCount != async_serial_pkg::BUF_DEPTH);
		// Majority of samples 8, 9 and 10 of the bit
		vote = (st.votes[0] & st.votes[1]) | (st.votes[0] & serialInPin)
			| (st.votes[1] & serialInPin);
		noisy = (st.votes[0] != st.votes[1]) || (st.votes[1] != serialInPin);
		// Stop bit position: one extra bit for 8N2, 8P1 and 9N1
		stopIdx = (layout == async_serial_pkg::LAYOUT_8N1)
			? async_serial_pkg::STOP_IDX_SHORT : async_serial_pkg::STOP_IDX_LONG;
		// Odd sense wants an odd count of ones over data and parity
		parityBad = (^st.shiftReg[8:0]) == st.frameCfg[async_serial_pkg::PARITY_SEL_BIT];

		// Oversample divider; the unused rate code gives no ticks at all
		if (st.baudCnt == 12'h000)
		begin
			next_st.baudCnt = async_serial_pkg::rate_reload(
				st.frameCfg[async_serial_pkg::RATE_LSB +: 3]);
			tick = (st.frameCfg[async_serial_pkg::RATE_LSB +: 3] != 3'h7);
		end
		else
		begin
			next_st.baudCnt = st.baudCnt - 12'h001;
		end

		// Receiver sequencer, held idle while disabled
		if (!st.frameCfg[async_serial_pkg::RX_ON_BIT])
		begin
			next_st.rxState = async_serial_pkg::RX_IDLE;
			next_st.history = 3'h0;
		end
		else if (tick)
		begin
			next_st.history = {st.history[1:0], serialInPin};
			next_st.sampleCnt = st.sampleCnt + 4'h1;
			if (st.sampleCnt == async_serial_pkg::VOTE_FIRST)
			begin
				next_st.votes[0] = serialInPin;
			end
			if (st.sampleCnt == async_serial_pkg::VOTE_MID)
			begin
				next_st.votes[1] = serialInPin;
			end
			case (st.rxState)
				async_serial_pkg::RX_IDLE:
				begin
					if (st.history == 3'h7 && !serialInPin)
					begin
						next_st.rxState = async_serial_pkg::RX_START;
						next_st.sampleCnt = 4'h1;
						next_st.bitCnt = 4'h0;
					end
				end
				async_serial_pkg::RX_START:
				begin
					if (st.sampleCnt == async_serial_pkg::VOTE_LAST)
					begin
						// A start that votes high was a glitch, not a frame
						next_st.rxState = vote ? async_serial_pkg::RX_IDLE
							: async_serial_pkg::RX_BITS;
						next_st.noiseAcc = noisy;
						next_st.lowRun = 4'h1;
					end
				end
				async_serial_pkg::RX_BITS:
				begin
					if (st.sampleCnt == async_serial_pkg::VOTE_LAST)
					begin
						bitDecided = 1'b1;
						next_st.bitCnt = st.bitCnt + 4'h1;
						next_st.shiftReg[st.bitCnt] = vote;
						next_st.noiseAcc = st.noiseAcc | noisy;
						next_st.lowRun = vote ? 4'h0 : st.lowRun + 4'h1;
						if (!vote && st.lowRun == async_serial_pkg::BREAK_BITS - 4'h1)
						begin
							next_st.breakFlag = 1'b1;
							next_st.breakIrq = 1'b1;
						end
						if (st.bitCnt == stopIdx)
						begin
							doneValid = 1'b1;
							doneChar.data = {(layout == async_serial_pkg::LAYOUT_9N1)
								& st.shiftReg[8], st.shiftReg[7:0]};
							doneChar.noise = st.noiseAcc | noisy;
							doneChar.framing = !vote
								| ((layout == async_serial_pkg::LAYOUT_8N2) & !st.shiftReg[8])
								| ((layout == async_serial_pkg::LAYOUT_8P1) & parityBad);
							next_st.rxState = async_serial_pkg::RX_IDLE;
						end
					end
				end
				default:
				begin
					next_st.rxState = async_serial_pkg::RX_IDLE;
				end
			endcase
		end

		// Status reads clear sticky flags first, so a same-cycle event still lands
		if (regRdStrobe && regAddr == async_serial_pkg::STATUS_ADDR)
		begin
			next_st.lostWord = 1'b0;
			if (!next_st.breakIrq)
			begin
				next_st.breakFlag = 1'b0;
			end
		end

		// Two-entry buffer; when it is full the finished character is dropped
		if (doneValid)
		begin
			if (fifoReady)
			begin
				next_st.fifo[st.wrPtr] = doneChar;
				next_st.wrPtr = ~st.wrPtr;
			end
			else
			begin
				next_st.lostWord = 1'b1;
			end
		end

		// Drain into the holding buffer only while it is empty
		if (st.fifoCount != 2'h0 && !st.holdFull)
		begin
			next_st.hold = st.fifo[st.rdPtr];
			next_st.holdFull = 1'b1;
			next_st.rdPtr = ~st.rdPtr;
		end
		next_st.fifoCount = st.fifoCount + {1'b0, doneValid & fifoReady}
			- {1'b0, st.fifoCount != 2'h0 && !st.holdFull};

		// Register reads: data stands in the following cycle only
		next_st.rdData = 8'h00;
		if (regRdStrobe)
		begin
			case (regAddr)
				async_serial_pkg::PIN_FN_ADDR: next_st.rdData = {4'h0, st.pinFn};
				async_serial_pkg::HOLD_ADDR:
				begin
					next_st.rdData = st.hold.data[7:0];
					// Reading an empty buffer must not cancel a load in the same cycle
					if (st.holdFull)
					begin
						next_st.holdFull = 1'b0;
					end
				end
				async_serial_pkg::STATUS_ADDR:
				begin
					next_st.rdData = {2'h0, st.hold.data[8], st.breakFlag, st.hold.framing,
						st.hold.noise, st.lostWord, st.holdFull};
				end
				async_serial_pkg::FRAME_CFG_ADDR: next_st.rdData = st.frameCfg;
				default: next_st.rdData = 8'h00;
			endcase
		end

		// Register writes; the holding and status registers are read-only
		if (regWrStrobe)
		begin
			case (regAddr)
				async_serial_pkg::PIN_FN_ADDR: next_st.pinFn = regWrData[3:0];
				async_serial_pkg::FRAME_CFG_ADDR: next_st.frameCfg = regWrData;
				default: next_st.pinFn = st.pinFn;
			endcase
		end

		// Pin routing is registered, adding one cycle to the transmit path
		next_st.serialOut = st.pinFn[async_serial_pkg::TX_PIN_SELECT]
			? portCOut : txSerial;
	end

	// ====================================================================
	// State register
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= '0;
			st.frameCfg <= async_serial_pkg::FRAME_CFG_RESET;
			st.pinFn <= async_serial_pkg::PIN_FN_RESET;
			st.serialOut <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ====================================================================
	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	rx_disabled_a: assert property (
		!st.frameCfg[async_serial_pkg::RX_ON_BIT] |=> st.rxState == async_serial_pkg::RX_IDLE)
		else $error("receiver active while disabled");

	start_detect_a: assert property (
		st.rxState == async_serial_pkg::RX_IDLE && st.frameCfg[async_serial_pkg::RX_ON_BIT]
		&& tick && st.history == 3'h7 && !serialInPin
		|=> st.rxState == async_serial_pkg::RX_START && st.sampleCnt == 4'h1)
		else $error("start condition missed");

	no_early_start_a: assert property (
		st.rxState == async_serial_pkg::RX_IDLE && st.history != 3'h7
		|=> st.rxState == async_serial_pkg::RX_IDLE)
		else $error("start taken without three high samples");

	stop_index_a: assert property (
		doneValid |-> st.bitCnt == (layout == async_serial_pkg::LAYOUT_8N1 ? 4'h8 : 4'h9))
		else $error("character length does not match layout");

	load_full_a: assert property (
		st.fifoCount != 2'h0 && !st.holdFull |=> st.holdFull ##0 st.hold == $past(st.fifo[st.rdPtr]))
		else $error("holding buffer load wrong");

	read_clears_a: assert property (
		regRdStrobe && regAddr == async_serial_pkg::HOLD_ADDR && !(st.fifoCount != 2'h0 && !st.holdFull)
		|=> !st.holdFull && regRdData == $past(st.hold.data[7:0]))
		else $error("holding read did not clear full");

	overrun_set_a: assert property (
		doneValid && st.fifoCount == async_serial_pkg::BUF_DEPTH |=> st.lostWord)
		else $error("overrun not flagged");

	hold_kept_a: assert property (
		st.holdFull && !(regRdStrobe && regAddr == async_serial_pkg::HOLD_ADDR)
		|=> $stable(st.hold) && st.holdFull)
		else $error("unread character altered");

	pin_route_a: assert property (
		st.pinFn[async_serial_pkg::TX_PIN_SELECT] && $stable(st.pinFn)
		|=> serialOutPin == $past(portCOut))
		else $error("shared pin not given to port C");

	stop_framing_a: assert property (
		doneValid && !vote |-> doneChar.framing)
		else $error("low stop bit not flagged");

	break_flag_a: assert property (
		bitDecided && !vote && st.lowRun == 4'h9 |=> breakIrq && st.breakFlag ##1 !breakIrq)
		else $error("break not flagged");

	back_idle_a: assert property (
		doneValid |=> st.rxState == async_serial_pkg::RX_IDLE)
		else $error("receiver did not return to idle");

	noise_bit_a: assert property (
		st.frameCfg[async_serial_pkg::RX_ON_BIT] && tick
		&& st.rxState == async_serial_pkg::RX_BITS
		&& st.sampleCnt == async_serial_pkg::VOTE_LAST
		&& st.votes[0] != serialInPin
		|=> st.noiseAcc)
		else $error("sample disagreement did not set noise");

	parity_fault_a: assert property (
		doneValid && layout == async_serial_pkg::LAYOUT_8P1
		&& (^st.shiftReg[8:0]) == st.frameCfg[async_serial_pkg::PARITY_SEL_BIT]
		|-> doneChar.framing)
		else $error("parity fault not flagged");

	lost_sticky_a: assert property (
		st.lostWord && !(regRdStrobe && regAddr == async_serial_pkg::STATUS_ADDR)
		|=> st.lostWord)
		else $error("overrun flag dropped before status read");

	break_sticky_a: assert property (
		st.breakFlag && !(regRdStrobe && regAddr == async_serial_pkg::STATUS_ADDR)
		|=> st.breakFlag)
		else $error("break flag dropped before status read");

	cover_overrun: cover property (doneValid && st.fifoCount == async_serial_pkg::BUF_DEPTH);
	cover_break: cover property (breakIrq);
	cover_parity: cover property (doneValid && layout == async_serial_pkg::LAYOUT_8P1);
	cover_noise: cover property (doneValid && doneChar.noise);
	cover_ninth: cover property (doneValid && layout == async_serial_pkg::LAYOUT_9N1);
endmodule

`default_nettype wire

// file: tb/serial_tx_model.sv
// Remote serial transmitter model that drives the receive line
`timescale 1ns/100ps
`default_nettype none

module serial_tx_model
#(
	parameter int BIT_CLKS = 656
)
(
	// Clock
	input wire logic ref_clk,
	// Frame request, bit 0 leaves first
	input wire logic go,
	input wire logic [11:0] frame,
	input wire logic [3:0] len,
	// Serial line
	output logic line
);
	logic [11:0] shreg = 12'h000;
	int bitsLeft = 0;
	int clkCnt = 0;

	// ====================================================================
	// Shifter
	// Each bit holds one full bit period; the line returns to its idle
	// high level once the last bit has run out, as a pulled-up line would
	initial line = 1'h1;
	always @(posedge ref_clk)
	begin
		if (go)
		begin
			shreg <= frame >> 1;
			line <= frame[0];
			bitsLeft <= int'(len);
			clkCnt <= BIT_CLKS - 1;
		end
		else if (bitsLeft != 0)
		begin
			if (clkCnt != 0)
				clkCnt <= clkCnt - 1;
			else
			begin
				bitsLeft <= bitsLeft - 1;
				clkCnt <= BIT_CLKS - 1;
				line <= (bitsLeft == 1) ? 1'h1 : shreg[0];
				shreg <= shreg >> 1;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/async_serial_receiver_test.sv
// Self-checking bench for the asynchronous serial receiver
`timescale 1ns/100ps
`default_nettype none

module async_serial_receiver_test;
	// Bit period at 38400 baud: sixteen ticks of 41 clocks
	localparam int BIT_CLKS = 656;
	logic ref_clk = 1'h0;
	logic resetn = 1'h0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrStrobe = 1'h0;
	logic regRdStrobe = 1'h0;
	logic [7:0] regRdData;
	logic serialInPin;
	logic txSerial = 1'h0;
	logic portCOut = 1'h0;
	logic serialOutPin;
	logic rxFullFlag;
	logic breakIrq;
	logic go = 1'h0;
	logic [11:0] frame = 12'hfff;
	logic [3:0] len = 4'h0;
	logic [7:0] rdVal;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int irqSeen = 0;

	always #20 ref_clk = ~ref_clk;

	async_serial_receiver u_dut
	(
		.ref_clk(ref_clk),
		.resetn(resetn),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWrStrobe(regWrStrobe),
		.regRdStrobe(regRdStrobe),
		.regRdData(regRdData),
		.serialInPin(serialInPin),
		.txSerial(txSerial),
		.portCOut(portCOut),
		.serialOutPin(serialOutPin),
		.rxFullFlag(rxFullFlag),
		.breakIrq(breakIrq)
	);

	serial_tx_model #(.BIT_CLKS(BIT_CLKS)) u_tx
	(
		.ref_clk(ref_clk),
		.go(go),
		.frame(frame),
		.len(len),
		.line(serialInPin)
	);

	// ====================================================================
	// Helpers
	task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStrobe <= 1'h1;
		@(posedge ref_clk);
		regWrStrobe <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe; taken mid-cycle
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStrobe <= 1'h1;
		@(posedge ref_clk);
		regRdStrobe <= 1'h0;
		@(negedge ref_clk);
		rdVal = regRdData;
	endtask

	// Rate 38400, receiver on; a pause lets the start detector see idle highs
	task automatic setcfg(input logic [1:0] lay, input logic sel);
		wr(async_serial_pkg::FRAME_CFG_ADDR, {3'h6, sel, lay, 2'h2});
		repeat (200) @(posedge ref_clk);
	endtask

	function automatic logic [11:0] mk(input logic [8:0] d, input logic [1:0] lay, input logic sel);
		logic [11:0] f;
		f = {3'h7, d[7:0], 1'h0};
		if (lay == 2'h2)
			f[9] = ^d[7:0] ^ ~sel;
		if (lay == 2'h3)
			f[9] = d[8];
		return f;
	endfunction

	// Fixed wait: a frame lasts its bit count times the bit period
	task automatic send(input logic [11:0] f, input logic [3:0] n);
		@(posedge ref_clk);
		frame <= f;
		len <= n;
		go <= 1'h1;
		@(posedge ref_clk);
		go <= 1'h0;
		repeat (int'(n) * BIT_CLKS + 40) @(posedge ref_clk);
	endtask

	task automatic expect_char(input logic [7:0] d, input logic fr, input logic nin);
		chk("full set", {7'h0, rxFullFlag}, 8'h01);
		rd(async_serial_pkg::STATUS_ADDR);
		chk("framing", {7'h0, rdVal[async_serial_pkg::ST_FRAMING]}, {7'h0, fr});
		chk("ninth", {7'h0, rdVal[async_serial_pkg::ST_NINTH]}, {7'h0, nin});
		chk("noise lost", {6'h0, rdVal[async_serial_pkg::ST_NOISE],
			rdVal[async_serial_pkg::ST_LOST]}, 8'h00);
		rd(async_serial_pkg::HOLD_ADDR);
		chk("hold data", rdVal, d);
		chk("full clear", {7'h0, rxFullFlag}, 8'h00);
	endtask

	task automatic one_char(input logic [1:0] lay, input logic sel, input logic [8:0] d,
		input logic [11:0] flip, input logic fr);
		setcfg(lay, sel);
		send(mk(d, lay, sel) ^ flip, (lay == 2'h0) ? 4'ha : 4'hb);
		expect_char(d[7:0], fr, (lay == 2'h3) ? d[8] : 1'h0);
	endtask

	// ====================================================================
	// Scenarios
	task automatic t_regs;
		rd(async_serial_pkg::FRAME_CFG_ADDR);
		chk("cfg reset", rdVal, 8'h00);
		rd(async_serial_pkg::STATUS_ADDR);
		chk("status reset", rdVal, 8'h00);
		wr(8'h20, 8'h55);
		wr(async_serial_pkg::HOLD_ADDR, 8'hff);
		rd(8'h20);
		chk("unmapped", rdVal, 8'h00);
		chk("hold read-only", {7'h0, rxFullFlag}, 8'h00);
		@(posedge ref_clk);
		portCOut <= 1'h1;
		repeat (3) @(posedge ref_clk);
		chk("pin to tx", {7'h0, serialOutPin}, 8'h00);
		wr(async_serial_pkg::PIN_FN_ADDR, 8'h08);
		repeat (3) @(posedge ref_clk);
		chk("pin to port", {7'h0, serialOutPin}, 8'h01);
		rd(async_serial_pkg::PIN_FN_ADDR);
		chk("pin fn", rdVal, 8'h08);
		$display("registers test done");
	endtask

	task automatic t_off;
		wr(async_serial_pkg::FRAME_CFG_ADDR, 8'hc0);
		send(mk(9'h03c, 2'h0, 1'h0), 4'ha);
		chk("off no char", {7'h0, rxFullFlag}, 8'h00);
		$display("receiver off test done");
	endtask

	task automatic t_layouts;
		one_char(2'h0, 1'h0, 9'h0a5, 12'h000, 1'h0);
		one_char(2'h2, 1'h0, 9'h05a, 12'h000, 1'h0);
		one_char(2'h2, 1'h1, 9'h05a, 12'h200, 1'h1);
		one_char(2'h3, 1'h0, 9'h1c3, 12'h000, 1'h0);
		one_char(2'h1, 1'h0, 9'h081, 12'h400, 1'h1);
		$display("layouts test done");
	endtask

	// Four characters unread: holding plus two waiting, the fourth is lost
	task automatic t_overrun;
		setcfg(2'h0, 1'h0);
		for (int i = 0; i < 4; i++)
			send(mk(9'(8'h10 + i), 2'h0, 1'h0), 4'ha);
		rd(async_serial_pkg::STATUS_ADDR);
		chk("overrun", {7'h0, rdVal[async_serial_pkg::ST_LOST]}, 8'h01);
		for (int i = 0; i < 3; i++)
		begin
			rd(async_serial_pkg::HOLD_ADDR);
			chk("kept order", rdVal, 8'(8'h10 + i));
			repeat (4) @(posedge ref_clk);
		end
		chk("drained", {7'h0, rxFullFlag}, 8'h00);
		$display("overrun test done");
	endtask

	task automatic t_break;
		int base;
		base = irqSeen;
		send(12'h000, 4'hb);
		chk("break irq", 8'(irqSeen - base), 8'h01);
		rd(async_serial_pkg::STATUS_ADDR);
		chk("break flag", {7'h0, rdVal[async_serial_pkg::ST_BREAK]}, 8'h01);
		$display("break test done");
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Cycle count, interrupt pulse count and hang limit
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (breakIrq === 1'h1)
			irqSeen <= irqSeen + 1;
		if (cycles == 90000)
		begin
			fail_count++;
			results;
		end
	end

	// Main sequence
	initial
	begin
		repeat (2) @(posedge ref_clk);
		chk("pin reset", {7'h0, serialOutPin}, 8'h01);
		chk("full reset", {7'h0, rxFullFlag}, 8'h00);
		resetn <= 1'h1;
		t_regs;
		t_off;
		t_layouts;
		t_overrun;
		t_break;
		results;
	end
endmodule
`default_nettype wire
